// ### eac_eeprom_ctrl.sv
// Data EEPROM access controller: I/O registers, arming window, stalls, ready interrupt
// ============================================================
// Behaviour
// - Ready interrupt enable gated by global enable
// - Ready interrupt is a level while idle
// - Program start accepted within four armed cycles
// - Program start ignored when not armed
// - Arming bit self-clears after four cycles
// - Program enable reads one until done
// - Program start stalls CPU two cycles
// - Read strobe loads data register immediately
// - Read strobe stalls CPU four cycles
// - Busy blocks reads and address writes
// - Mode 00 erases then writes atomically
// - Mode 01 erases only
// - Mode 10 writes only
// - Other operations refused while programming
// - Programming timed from trimmed oscillator
// - Reset does not abort programming
// - Bit operations only on low I/O range
// - I/O window, data space plus offset
// - Bit operations touch only one bit
// - Mode writes ignored while programming
// - Reset clears mode unless busy
// - Atomic 3.4 ms, split 1.8 ms
`timescale 1ns/1ps
`include "eac_consts.svh"
module eac_eeprom_ctrl
    import eac_pkg::*;
#(
    parameter int ADDR_W            = 9,
    parameter int TICK_CYC          = `EAC_TICK_NS / `EAC_CLK_NS,
    parameter int PROG_TICKS_ATOMIC = int'(`EAC_T_ATOMIC_MS * 1.0e6 / `EAC_TICK_NS),
    parameter int PROG_TICKS_SPLIT  = int'(`EAC_T_SPLIT_MS * 1.0e6 / `EAC_TICK_NS)
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic         por_n,
    input  wire eac_bus_req_s bus_req,
    input  wire logic         global_int_en,
    input  wire logic [7:0]   osc_trim,
    output logic      [7:0]   rd_data,
    output logic              rd_valid,
    output logic              cpu_stall,
    output logic              ready_irq,
    output logic              prog_busy
);

    // ============================================================
    // Elaboration checks
    if (ADDR_W < 1 || ADDR_W > 16) begin : g_chk_addr
        $error("eac_eeprom_ctrl: ADDR_W must be 1..16");
    end
    if (TICK_CYC < 130 || TICK_CYC > 65000) begin : g_chk_tick
        $error("eac_eeprom_ctrl: TICK_CYC must leave room for the trim span");
    end

    // ============================================================
    // Helpers

    // Map an access to an I/O index; bit 6 says the address hits the I/O window
    function automatic logic [6:0] io_index(input eac_bus_req_s r);
        logic [7:0] a;
        a = r.addr - `EAC_DS_OFFSET;
        if (r.data_space) begin
            io_index = {(r.addr >= `EAC_DS_OFFSET) && (r.addr <= `EAC_DS_MAX), a[5:0]};
        end else begin
            io_index = {(r.addr <= `EAC_IO_MAX), r.addr[5:0]};
        end
    endfunction

    // Replace only the bits selected by the mask
    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] mask,
                                         input logic [7:0] val);
        merge = (old_v & ~mask) | (val & mask);
    endfunction

    // ============================================================
    // Access decode
    logic [6:0] idx_full;
    logic [5:0] io_idx;
    logic       io_hit;
    logic       bit_op;
    logic       bit_ok;
    logic       wr_en;
    logic [7:0] wr_mask;
    logic [7:0] wr_val;
    logic       sel_ctrl;
    logic       sel_data;
    logic       sel_alo;
    logic       sel_ahi;
    logic       ctrl_wr;

    assign idx_full = io_index(bus_req);
    assign io_idx   = idx_full[5:0];
    assign io_hit   = bus_req.valid && idx_full[6];
    assign bit_op   = (bus_req.op == EAC_OP_SET) || (bus_req.op == EAC_OP_CLR);
    // Bit set/clear is dropped outside the low I/O range or from data space
    assign bit_ok   = !bus_req.data_space && (io_idx <= `EAC_BIT_IO_MAX);
    assign wr_en    = io_hit && (bus_req.op == EAC_OP_WRITE || (bit_op && bit_ok));
    assign sel_ctrl = (io_idx == `EAC_OFS_CTRL);
    assign sel_data = (io_idx == `EAC_OFS_DATA);
    assign sel_alo  = (io_idx == `EAC_OFS_ADDR_LO);
    assign sel_ahi  = (io_idx == `EAC_OFS_ADDR_HI);
    assign ctrl_wr  = wr_en && sel_ctrl;

    // Mask and value of a write; a bit op touches its one bit only
    always_comb begin
        wr_mask = 8'h00;
        wr_val  = 8'h00;
        case (bus_req.op)
            EAC_OP_WRITE: begin
                wr_mask = 8'hff;
                wr_val  = bus_req.wdata;
            end
            EAC_OP_SET: begin
                wr_mask = 8'(8'h01 << bus_req.bit_idx);
                wr_val  = 8'hff;
            end
            EAC_OP_CLR: begin
                wr_mask = 8'(8'h01 << bus_req.bit_idx);
                wr_val  = 8'h00;
            end
            default: begin
                wr_mask = 8'h00;
                wr_val  = 8'h00;
            end
        endcase
    end

    // Strobe bits act only where a one lands in the written lanes
    logic re_one;
    logic pe_one;
    logic mpe_wr;
    logic rie_wr;
    logic pm_wr;

    assign re_one = ctrl_wr && wr_mask[`EAC_B_RE] && wr_val[`EAC_B_RE];
    assign pe_one = ctrl_wr && wr_mask[`EAC_B_PE] && wr_val[`EAC_B_PE];
    assign mpe_wr = ctrl_wr && wr_mask[`EAC_B_MPE];
    assign rie_wr = ctrl_wr && wr_mask[`EAC_B_RIE];
    assign pm_wr  = ctrl_wr && (wr_mask[`EAC_B_PM_HI] || wr_mask[`EAC_B_PM_LO]);

    // ============================================================
    // Reset release seen from the power-on domain
    logic rst_q1_reg;
    logic rst_q2_reg;
    logic rst_q1_next;
    logic rst_q2_next;

    // The pin level passes two flops; only the second one is read
    always_comb begin
        rst_q1_next = rstn;
        rst_q2_next = rst_q1_reg;
    end

    always_ff @(posedge clk_sys or negedge por_n) begin
        if (!por_n) begin
            rst_q1_reg <= 1'b0;
            rst_q2_reg <= 1'b0;
        end else begin
            rst_q1_reg <= rst_q1_next;
            rst_q2_reg <= rst_q2_next;
        end
    end

    // ============================================================
    // Oscillator tick divider
    logic [15:0] div_reg;
    logic [15:0] div_next;
    logic [15:0] div_load;
    logic        tick;

    // Trim shifts the tick period around its nominal value, so it scales all program times
    assign div_load = 16'(TICK_CYC) + {8'h00, osc_trim} - `EAC_TRIM_NOMINAL;
    assign tick     = (div_reg == 16'h0000);

    always_comb begin
        if (tick) begin
            div_next = div_load - 16'h0001;
        end else begin
            div_next = div_reg - 16'h0001;
        end
    end

    // Cleared only on power-on reset, so a CPU reset leaves an operation in flight its time base
    always_ff @(posedge clk_sys or negedge por_n) begin
        if (!por_n) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_next;
        end
    end

    // ============================================================
    // Programming engine and array
    logic              busy;
    logic              start;
    logic [1:0]        mode_reg;
    logic [1:0]        mode_next;
    logic [15:0]       addr_reg;
    logic [15:0]       addr_next;
    logic [15:0]       addr_mask;
    logic [7:0]        data_reg;
    logic [7:0]        data_next;
    logic [7:0]        rd_byte;
    logic [2:0]        arm_reg;
    logic [2:0]        arm_next;
    logic              armed;

    assign addr_mask = 16'((17'h00001 << ADDR_W) - 17'h00001);
    assign armed     = (arm_reg != 3'h0);
    // Armed, idle and a defined mode are all needed to start
    assign start     = pe_one && armed && !busy && (mode_reg != `EAC_MODE_RSVD);

    eac_nvm_array #(
        .ADDR_W            (ADDR_W),
        .PROG_TICKS_ATOMIC (PROG_TICKS_ATOMIC),
        .PROG_TICKS_SPLIT  (PROG_TICKS_SPLIT)
    ) u_array (
        .clk_sys (clk_sys),
        .por_n   (por_n),
        .tick    (tick),
        .start   (start),
        .mode    (mode_reg),
        .addr    (addr_reg[ADDR_W-1:0]),
        .wdata   (data_reg),
        .rd_addr (addr_reg[ADDR_W-1:0]),
        .rd_byte (rd_byte),
        .busy    (busy)
    );

    // ============================================================
    // Mode field: lives in the power-on domain so a CPU reset can spare it
    always_comb begin
        mode_next = mode_reg;
        if (!rst_q2_reg && !busy) begin
            mode_next = `EAC_MODE_ATOMIC;
        end else if (pm_wr && !busy) begin
            mode_next = 2'(merge({6'h00, mode_reg} << `EAC_B_PM_LO, wr_mask, wr_val)
                           >> `EAC_B_PM_LO);
        end
    end

    always_ff @(posedge clk_sys or negedge por_n) begin
        if (!por_n) begin
            mode_reg <= `EAC_MODE_ATOMIC;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ============================================================
    // Arming window, interrupt enable, address and data registers
    logic rie_reg;
    logic rie_next;

    always_comb begin
        arm_next  = arm_reg;
        rie_next  = rie_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        // Window counts down four cycles; a start consumes it
        if (mpe_wr) begin
            arm_next = wr_val[`EAC_B_MPE] ? `EAC_ARM_CYC : 3'h0;
        end else if (start) begin
            arm_next = 3'h0;
        end else if (armed) begin
            arm_next = arm_reg - 3'h1;
        end
        if (rie_wr) begin
            rie_next = wr_val[`EAC_B_RIE];
        end
        // Address stays frozen while an operation is running
        if (wr_en && sel_alo && !busy) begin
            addr_next[7:0] = merge(addr_reg[7:0], wr_mask, wr_val) & addr_mask[7:0];
        end
        if (wr_en && sel_ahi && !busy) begin
            addr_next[15:8] = merge(addr_reg[15:8], wr_mask, wr_val) & addr_mask[15:8];
        end
        if (wr_en && sel_data) begin
            data_next = merge(data_reg, wr_mask, wr_val);
        end
        // Read strobe lands the byte the very next cycle; refused while busy
        if (re_one && !busy) begin
            data_next = rd_byte;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            arm_reg  <= 3'h0;
            rie_reg  <= 1'b0;
            addr_reg <= 16'h0000;
            data_reg <= 8'h00;
        end else begin
            arm_reg  <= arm_next;
            rie_reg  <= rie_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
        end
    end

    // ============================================================
    // CPU stall counter
    logic [2:0] stall_reg;
    logic [2:0] stall_next;

    always_comb begin
        stall_next = stall_reg;
        if (re_one && !busy) begin
            stall_next = `EAC_STALL_RD_CYC;
        end else if (start) begin
            stall_next = `EAC_STALL_PG_CYC;
        end else if (stall_reg != 3'h0) begin
            stall_next = stall_reg - 3'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stall_reg <= 3'h0;
        end else begin
            stall_reg <= stall_next;
        end
    end

    // ============================================================
    // Read response, one cycle after the access
    logic [7:0] rsp_next;
    logic       rv_next;
    logic [7:0] ctrl_view;

    // Read strobe reads back as zero since it completes at once
    always_comb begin
        ctrl_view                 = `EAC_CTRL_RESET;
        ctrl_view[`EAC_B_PM_HI]   = mode_reg[1];
        ctrl_view[`EAC_B_PM_LO]   = mode_reg[0];
        ctrl_view[`EAC_B_RIE]     = rie_reg;
        ctrl_view[`EAC_B_MPE]     = armed;
        ctrl_view[`EAC_B_PE]      = busy;
    end

    always_comb begin
        rv_next  = io_hit && (bus_req.op == EAC_OP_READ);
        rsp_next = 8'h00;
        if (rv_next) begin
            case (io_idx)
                `EAC_OFS_CTRL:    rsp_next = ctrl_view;
                `EAC_OFS_DATA:    rsp_next = data_reg;
                `EAC_OFS_ADDR_LO: rsp_next = addr_reg[7:0];
                `EAC_OFS_ADDR_HI: rsp_next = addr_reg[15:8];
                default:          rsp_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= rsp_next;
            rd_valid <= rv_next;
        end
    end

    // ============================================================
    // Status outputs
    assign cpu_stall = (stall_reg != 3'h0);
    // Level request for as long as the array is idle and enabled
    assign ready_irq = rie_reg && global_int_en && !busy;
    assign prog_busy = busy;

endmodule

// ### eac_consts.svh
// Offsets, field positions, encodings and timing figures of the EEPROM access block
`ifndef EAC_CONSTS_SVH
`define EAC_CONSTS_SVH

// ============================================================
// I/O register offsets and address windows
`define EAC_OFS_CTRL      6'h10
`define EAC_OFS_DATA      6'h11
`define EAC_OFS_ADDR_LO   6'h12
`define EAC_OFS_ADDR_HI   6'h13
`define EAC_IO_MAX        8'h3f
`define EAC_BIT_IO_MAX    6'h1f
`define EAC_DS_OFFSET     8'h20
`define EAC_DS_MAX        8'h5f

// ============================================================
// Control register fields
`define EAC_B_RE          0
`define EAC_B_PE          1
`define EAC_B_MPE         2
`define EAC_B_RIE         3
`define EAC_B_PM_LO       4
`define EAC_B_PM_HI       5
`define EAC_CTRL_RESET    8'h00

// ============================================================
// Programming modes and cell values
`define EAC_MODE_ATOMIC   2'b00
`define EAC_MODE_ERASE    2'b01
`define EAC_MODE_WRITE    2'b10
`define EAC_MODE_RSVD     2'b11
`define EAC_ERASED_BYTE   8'hff

// ============================================================
// Timing
`define EAC_CLK_NS        4
`define EAC_TICK_NS       1000
`define EAC_T_ATOMIC_MS   3.4
`define EAC_T_SPLIT_MS    1.8
`define EAC_ARM_CYC       3'h4
`define EAC_STALL_RD_CYC  3'h4
`define EAC_STALL_PG_CYC  3'h2
`define EAC_TRIM_NOMINAL  16'h0080

`endif

// ### eac_pkg.sv
// Types shared by the EEPROM access block
package eac_pkg;

    // ============================================================
    // CPU access kinds
    typedef enum logic [1:0] {
        EAC_OP_READ,
        EAC_OP_WRITE,
        EAC_OP_SET,
        EAC_OP_CLR
    } eac_op_e;

    // One CPU access per cycle, I/O space or data space
    typedef struct packed {
        logic       valid;
        eac_op_e    op;
        logic       data_space;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [2:0] bit_idx;
    } eac_bus_req_s;

    // Programming engine states
    typedef enum logic {
        EAC_NV_IDLE,
        EAC_NV_BUSY
    } eac_nv_state_e;

endpackage

// ### eac_nvm_array.sv
// Data EEPROM cell array with its self-timed programming engine
`timescale 1ns/1ps
`include "eac_consts.svh"
module eac_nvm_array
    import eac_pkg::*;
#(
    parameter int ADDR_W            = 9,
    parameter int PROG_TICKS_ATOMIC = 3400,
    parameter int PROG_TICKS_SPLIT  = 1800
) (
    input  wire logic              clk_sys,
    input  wire logic              por_n,
    input  wire logic              tick,
    input  wire logic              start,
    input  wire logic [1:0]        mode,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [7:0]        rd_byte,
    output logic                   busy
);

    // ============================================================
    // Storage and engine state
    logic [7:0]        mem [0:(1<<ADDR_W)-1];
    eac_nv_state_e     state_reg,  state_next;
    logic [15:0]       cnt_reg,    cnt_next;
    logic [1:0]        op_mode_reg, op_mode_next;
    logic [ADDR_W-1:0] op_addr_reg, op_addr_next;
    logic [7:0]        op_data_reg, op_data_next;
    logic              commit;

    if (PROG_TICKS_ATOMIC < 1 || PROG_TICKS_ATOMIC > 65535 ||
        PROG_TICKS_SPLIT < 1 || PROG_TICKS_SPLIT > 65535) begin : g_chk
        $error("eac_nvm_array: programming tick counts out of range");
    end

    // Array read is immediate, so a read strobe completes in one access
    assign rd_byte = mem[rd_addr];
    assign busy    = (state_reg == EAC_NV_BUSY);

    // Next engine state; operands are latched so later register writes cannot alter it
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        op_mode_next = op_mode_reg;
        op_addr_next = op_addr_reg;
        op_data_next = op_data_reg;
        commit       = 1'b0;
        case (state_reg)
            EAC_NV_IDLE: begin
                if (start) begin
                    state_next   = EAC_NV_BUSY;
                    op_mode_next = mode;
                    op_addr_next = addr;
                    op_data_next = wdata;
                    if (mode == `EAC_MODE_ATOMIC) begin
                        cnt_next = 16'(PROG_TICKS_ATOMIC);
                    end else begin
                        cnt_next = 16'(PROG_TICKS_SPLIT);
                    end
                end
            end
            EAC_NV_BUSY: begin
                if (tick) begin
                    if (cnt_reg <= 16'h0001) begin
                        commit     = 1'b1;
                        state_next = EAC_NV_IDLE;
                        cnt_next   = 16'h0000;
                    end else begin
                        cnt_next = cnt_reg - 16'h0001;
                    end
                end
            end
            default: state_next = EAC_NV_IDLE;
        endcase
    end

    // Only power-on clears the engine, so a CPU reset lets the operation finish
    always_ff @(posedge clk_sys or negedge por_n) begin
        if (!por_n) begin
            state_reg   <= EAC_NV_IDLE;
            cnt_reg     <= 16'h0000;
            op_mode_reg <= `EAC_MODE_ATOMIC;
            op_addr_reg <= '0;
            op_data_reg <= 8'h00;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            op_mode_reg <= op_mode_next;
            op_addr_reg <= op_addr_next;
            op_data_reg <= op_data_next;
        end
    end

    // Cells change at the end of the operation; write-only can only clear bits
    always_ff @(posedge clk_sys) begin
        if (commit) begin
            case (op_mode_reg)
                `EAC_MODE_ATOMIC: mem[op_addr_reg] <= op_data_reg;
                `EAC_MODE_ERASE:  mem[op_addr_reg] <= `EAC_ERASED_BYTE;
                `EAC_MODE_WRITE:  mem[op_addr_reg] <= mem[op_addr_reg] & op_data_reg;
                default:          mem[op_addr_reg] <= mem[op_addr_reg];
            endcase
        end
    end

endmodule

// ### eac_eeprom_ctrl_assertions.sv
// Port checker for the EEPROM access controller
`timescale 1ns/1ps
module eac_ctrl_chk
    import eac_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rstn,
    input wire logic         por_n,
    input wire eac_bus_req_s bus_req,
    input wire logic         global_int_en,
    input wire logic         rd_valid,
    input wire logic         cpu_stall,
    input wire logic         ready_irq,
    input wire logic         prog_busy
);
    // ============================================================
    // Control bit strobes, bit-set form only
    wire logic ctl    = bus_req.valid && !bus_req.data_space && bus_req.addr == 8'h10;
    wire logic setb   = ctl && bus_req.op == EAC_OP_SET;
    wire logic rd_stb = setb && bus_req.bit_idx == 3'h0;
    wire logic arm    = setb && bus_req.bit_idx == 3'h2;
    wire logic go     = setb && bus_req.bit_idx == 3'h1;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn || !por_n);

    // ============================================================
    // Properties
    chk_irq_gate: assert property (ready_irq |-> global_int_en && !prog_busy)
        else $error("ready irq without enable or while busy");
    chk_rd_answer: assert property (bus_req.valid && bus_req.op == EAC_OP_READ
        && !bus_req.data_space && bus_req.addr <= 8'h3f |=> rd_valid)
        else $error("no read answer");
    chk_rd_cause: assert property (rd_valid |-> $past(bus_req.valid))
        else $error("read answer without request");
    chk_rd_stall: assert property (rd_stb && !prog_busy |=> cpu_stall[*4] ##1 !cpu_stall)
        else $error("read stall length wrong");
    chk_pg_stall: assert property ($rose(prog_busy) |-> cpu_stall[*2] ##1 !cpu_stall)
        else $error("program stall length wrong");
    chk_arm_start: assert property (arm && !prog_busy ##1 go |=> prog_busy)
        else $error("armed start not taken");
    chk_arm_expire: assert property (arm ##1 (!go && !arm)[*4] ##1 (go && !prog_busy)
        |=> !prog_busy)
        else $error("start taken after arm window");
    chk_busy_block: assert property (prog_busy && !cpu_stall && rd_stb |=> !cpu_stall)
        else $error("read strobe honoured while busy");
    chk_busy_min: assert property ($rose(prog_busy) |-> prog_busy[*8])
        else $error("busy dropped early");

    cover property ($rose(prog_busy));
    cover property (rd_stb && !prog_busy);
    cover property (ready_irq);
endmodule

bind eac_eeprom_ctrl eac_ctrl_chk chk_i (.clk_sys(clk_sys), .rstn(rstn), .por_n(por_n),
    .bus_req(bus_req), .global_int_en(global_int_en), .rd_valid(rd_valid),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq), .prog_busy(prog_busy));

// ### tb_eeprom_access_control.sv
// Self-checking bench for the EEPROM access controller
`timescale 1ns/1ps
module tb_eeprom_access_control
    import eac_pkg::*;
();
    logic         clk_sys = 1'b0, rstn = 1'b0, por_n = 1'b0, gie = 1'b1;
    logic [7:0]   trim = 8'h80, rd_data;
    logic         rd_valid, cpu_stall, ready_irq, prog_busy;
    eac_bus_req_s req = '0;
    int           err_total = 0, tests_run = 0, cyc = 0, n, t0;
    // Rows: data space, write addr, write data, read addr, expected
    logic [7:0] rows [6][5] = '{'{8'h00, 8'h11, 8'h5a, 8'h11, 8'h5a},
        '{8'h01, 8'h31, 8'ha5, 8'h11, 8'ha5}, '{8'h01, 8'h32, 8'h3c, 8'h12, 8'h3c},
        '{8'h00, 8'h13, 8'hff, 8'h13, 8'h01}, '{8'h00, 8'h10, 8'hf8, 8'h10, 8'h38},
        '{8'h00, 8'h3e, 8'h77, 8'h3e, 8'h00}};
    // Runs: mode, data, arm gap, trim, ticks, expected cell
    logic [7:0] runs [3][6] = '{'{8'h01, 8'h00, 8'h00, 8'h80, 8'h03, 8'hff},
        '{8'h02, 8'h3c, 8'h03, 8'h88, 8'h03, 8'h3c}, // Write-only after erase
        '{8'h00, 8'ha5, 8'h00, 8'h80, 8'h05, 8'ha5}};

    // Short counts keep each programming run to a few hundred cycles
    eac_eeprom_ctrl #(.TICK_CYC(130), .PROG_TICKS_ATOMIC(5), .PROG_TICKS_SPLIT(3)) uut (
        .clk_sys(clk_sys), .rstn(rstn), .por_n(por_n), .bus_req(req), .global_int_en(gie),
        .osc_trim(trim), .rd_data(rd_data), .rd_valid(rd_valid), .cpu_stall(cpu_stall),
        .ready_irq(ready_irq), .prog_busy(prog_busy));

    // ============================================================
    // Clock, watchdog and shared tasks
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input eac_op_e op, input logic ds, input logic [7:0] a, wd,
                       input logic [2:0] b);
        @(negedge clk_sys);
        req = '{1'b1, op, ds, a, wd, b};
    endtask
    task automatic idle(input int k);
        repeat (k) begin
            @(negedge clk_sys);
            req.valid = 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(EAC_OP_READ, 1'b0, a, 8'h00, 3'h0);
        idle(1);
        chk({rd_valid, rd_data}, {1'b1, exp});
    endtask
    task automatic wait_idle();
        n = 0;
        while (prog_busy === 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        // A hung engine is a failure, not a silent fall-through
        if (n >= 2000) begin
            err_total++;
            wrap_up();
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (16) @(negedge clk_sys);
        rstn = 1'b1;
        por_n = 1'b1;
        idle(3);
        rd(8'h10, 8'h00);
        foreach (rows[i]) begin
            acc(EAC_OP_WRITE, rows[i][0][0], rows[i][1], rows[i][2], 3'h0);
            rd(rows[i][3], rows[i][4]);
        end
        // Bit set and clear touch one bit; data-space form refused
        acc(EAC_OP_WRITE, 1'b0, 8'h10, 8'h00, 3'h0);
        acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h3);
        acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h5);
        acc(EAC_OP_CLR, 1'b1, 8'h30, 8'h00, 3'h3);
        rd(8'h10, 8'h28);
        chk(ready_irq, 1'b1);
        gie = 1'b0;
        idle(1);
        chk(ready_irq, 1'b0);
        gie = 1'b1;
        acc(EAC_OP_CLR, 1'b0, 8'h10, 8'h00, 3'h5);
        rd(8'h10, 8'h08);
        // Modes 01, 10 and 00, with the arm window at both ends; busy refuses other work
        foreach (runs[i]) begin
            trim = runs[i][3];
            acc(EAC_OP_WRITE, 1'b0, 8'h12, 8'h05, 3'h0);
            acc(EAC_OP_WRITE, 1'b0, 8'h11, runs[i][1], 3'h0);
            acc(EAC_OP_WRITE, 1'b0, 8'h10, {2'b00, runs[i][0][1:0], 4'h8}, 3'h0);
            acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h2);
            idle(runs[i][2]);
            acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h1);
            idle(1);
            t0 = cyc;
            chk({prog_busy, cpu_stall, ready_irq}, 3'b110);
            acc(EAC_OP_WRITE, 1'b0, 8'h10, 8'h08, 3'h0);
            acc(EAC_OP_WRITE, 1'b0, 8'h12, 8'h77, 3'h0);
            acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h0);
            rd(8'h10, {2'b00, runs[i][0][1:0], 4'ha});
            rd(8'h12, 8'h05);
            wait_idle();
            // First tick lands within one period; a period in flight keeps the old trim
            chk(cyc - t0 > (int'(runs[i][4]) - 1) * (int'(runs[i][3]) + 2)
                && cyc - t0 <= int'(runs[i][4]) * (int'(runs[i][3]) + 2) + 8, 1'b1);
            acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h0);
            rd(8'h11, runs[i][5]);
            idle(4);
        end
        // Start one cycle past the window is dropped
        acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h2);
        idle(4);
        acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h1);
        idle(1);
        chk(prog_busy, 1'b0);
        rd(8'h10, 8'h08);
        // Reset in mid-operation keeps the operation and its mode
        acc(EAC_OP_WRITE, 1'b0, 8'h10, 8'h10, 3'h0);
        acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h2);
        acc(EAC_OP_SET, 1'b0, 8'h10, 8'h00, 3'h1);
        idle(20);
        rstn = 1'b0;
        idle(8);
        chk(prog_busy, 1'b1);
        rstn = 1'b1;
        idle(3);
        rd(8'h10, 8'h12);
        wait_idle();
        rd(8'h10, 8'h10);
        // Reset while idle returns the mode to zero
        rstn = 1'b0;
        idle(4);
        rstn = 1'b1;
        idle(3);
        rd(8'h10, 8'h00);
        wrap_up();
    end
endmodule
